//--- hw/adcsc_seq_ctrl.v
// Sequence control and status of an eight-channel converter, APB slave.
// Assumes a converter core on pclk that takes conv_start, converts the
// channel on conv_channel and returns conv_done with conv_data.
// The external trigger arrives asynchronously on a pin.
`timescale 1ns/10ps
`include "adcsc_defs.vh"

module adcsc_seq_ctrl (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire ext_trigger,
   input wire special_mode,
   input wire conv_done,
   input wire [9:0] conv_data,
   output wire conv_start,
   output wire conv_abort,
   output wire [2:0] conv_channel,
   output wire conv_low_res,
   output wire seq_busy
);

   // ****************************************************************
   // Functions
   // ****************************************************************

   // Places a raw 10-bit code by resolution, justification and sign
   function [15:0] adcsc_format;
      input [9:0] d;
      input lo;
      input rj;
      input sg;
      reg [15:0] v;
      begin
         v = 16'h0000;
         if (rj) begin
            v = lo ? {8'h00, d[9:2]} : {6'h00, d};
         end else begin
            v = lo ? {d[9:2], 8'h00} : {d, 6'h00};
            if (sg) begin
               v[15] = ~v[15];
            end
         end
         adcsc_format = v;
      end
   endfunction

   // Length 0 or above 8 means a full sequence of 8
   function [3:0] adcsc_len;
      input [3:0] s;
      begin
         adcsc_len = (s == 4'h0 || s > `ADCSC_MAX_LEN) ?
                     `ADCSC_MAX_LEN : s;
      end
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   reg pready_ff, pslverr_ff;
   reg [31:0] prdata_ff;
   reg [7:0] ctl_two_ff, ctl_three_ff, ctl_four_ff, seq_ctl_ff;
   reg [7:0] test_ff, lfsr_ff;
   reg done_ff, trig_ovr_ff, res_ovr_ff, armed_ff;
   reg [7:0] ccf_ff;
   reg [2:0] cnt_ff, chan_ff;
   reg [3:0] pos_ff;
   reg busy_ff, wait_ff, start_ff, abort_ff;
   reg trig_s1_ff, trig_s2_ff, trig_s3_ff, trig_lvl_ff, trig_prev_ff;
   reg [15:0] result_ff [0:7];

   reg nxt_done, nxt_trig_ovr, nxt_res_ovr, nxt_armed;
   reg [7:0] nxt_ccf;
   reg [2:0] nxt_cnt, nxt_chan;
   reg [3:0] nxt_pos;
   reg nxt_busy, nxt_wait, nxt_start, nxt_abort;
   reg store, seq_end;
   reg [31:0] rd_mux;
   reg rd_err;
   integer i;

   // ****************************************************************
   // Bus decode
   // ****************************************************************

   // Access phase is taken once pready_ff has been raised by setup
   wire access = psel & penable & pready_ff;
   wire wr_en = access & pwrite;
   wire rd_en = access & ~pwrite;
   wire is_res = (paddr[7:5] == `ADCSC_RES_BASE_HI) & (paddr[1:0] == 2'h0);
   wire [2:0] res_idx = paddr[4:2];
   wire wr_c2 = wr_en & (paddr == `ADCSC_OFF_CTL_TWO);
   wire wr_c3 = wr_en & (paddr == `ADCSC_OFF_CTL_THREE);
   wire wr_c4 = wr_en & (paddr == `ADCSC_OFF_CTL_FOUR);
   wire wr_c5 = wr_en & (paddr == `ADCSC_OFF_SEQ_CTL);
   wire wr_st = wr_en & (paddr == `ADCSC_OFF_SEQ_STAT);
   wire wr_tst = wr_en & (paddr == `ADCSC_OFF_TEST_ZERO);
   wire rd_ccf = rd_en & (paddr == `ADCSC_OFF_DONE_FLAGS);
   wire rd_res = rd_en & is_res;

   // Control fields used by the sequencer and the status flags
   wire fast_clr = ctl_two_ff[`ADCSC_C2_FAST_CLR];
   wire level_mode = ctl_two_ff[`ADCSC_C2_TRIG_EDGE_SEL];
   wire trig_en = ctl_two_ff[`ADCSC_C2_TRIG_EN];
   wire fifo_mode = ctl_three_ff[`ADCSC_C3_FIFO];
   wire [3:0] seq_len = adcsc_len(ctl_three_ff[3:0]);
   wire [3:0] pos_inc = pos_ff + 4'h1;

   // Any write to controls two to five aborts; five also starts
   wire abort_req = wr_c2 | wr_c3 | wr_c4 | wr_c5;

   // ****************************************************************
   // Trigger synchroniser
   // ****************************************************************

   // Three stages; a level change counts once stages two and three agree
   wire trig_edge = trig_lvl_ff & ~trig_prev_ff;
   wire trig_start = trig_en & ~abort_req & ~busy_ff &
                     (level_mode ? trig_lvl_ff : trig_edge);
   wire trig_overrun = trig_en & ~level_mode & trig_edge &
                       busy_ff;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_s1_ff <= 1'b0;
         trig_s2_ff <= 1'b0;
         trig_s3_ff <= 1'b0;
         trig_lvl_ff <= 1'b0;
         trig_prev_ff <= 1'b0;
      end else begin
         trig_s1_ff <= ext_trigger;
         trig_s2_ff <= trig_s1_ff;
         trig_s3_ff <= trig_s2_ff;
         if (trig_s2_ff == trig_s3_ff) begin
            trig_lvl_ff <= trig_s3_ff;
         end
         trig_prev_ff <= trig_lvl_ff;
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************

   // One conversion at a time: start, wait for done, store, step
   always @* begin
      nxt_busy = busy_ff;
      nxt_wait = wait_ff;
      nxt_pos = pos_ff;
      nxt_chan = chan_ff;
      nxt_cnt = cnt_ff;
      nxt_start = 1'b0;
      nxt_abort = 1'b0;
      store = 1'b0;
      seq_end = 1'b0;
      if (abort_req) begin
         // In-flight conversion is dropped so no stale result lands
         nxt_abort = wait_ff;
         nxt_busy = wr_c5;
         nxt_wait = 1'b0;
         nxt_pos = 4'h0;
         nxt_chan = pwdata[2:0];
         nxt_cnt = 3'h0;
         if (!wr_c5) begin
            nxt_chan = seq_ctl_ff[2:0];
         end
      end else if (trig_start) begin
         nxt_busy = 1'b1;
         nxt_wait = 1'b0;
         nxt_pos = 4'h0;
         nxt_chan = seq_ctl_ff[2:0];
         if (!fifo_mode) begin
            nxt_cnt = 3'h0;
         end
      end else if (busy_ff) begin
         if (!wait_ff) begin
            nxt_start = 1'b1;
            nxt_wait = 1'b1;
         end else if (conv_done) begin
            store = 1'b1;
            nxt_wait = 1'b0;
            nxt_cnt = cnt_ff + 3'h1;
            nxt_pos = pos_inc;
            if (seq_ctl_ff[`ADCSC_SC_MULTI]) begin
               nxt_chan = chan_ff + 3'h1;
            end
            if (pos_inc == seq_len) begin
               seq_end = 1'b1;
               nxt_pos = 4'h0;
               if (!fifo_mode) begin
                  nxt_cnt = 3'h0;
               end
               if (seq_ctl_ff[`ADCSC_SC_MULTI]) begin
                  nxt_chan = seq_ctl_ff[2:0];
               end
               nxt_busy = seq_ctl_ff[`ADCSC_SC_CONT];
            end
         end
      end
   end

   // ****************************************************************
   // Status flags
   // ****************************************************************

   // Clears first, hardware sets last so a coincident event is kept
   always @* begin
      nxt_done = done_ff;
      nxt_trig_ovr = trig_ovr_ff;
      nxt_res_ovr = res_ovr_ff;
      nxt_ccf = ccf_ff;
      nxt_armed = armed_ff;
      // Writing zero to a flag leaves it alone
      if (wr_st & pwdata[`ADCSC_ST_DONE]) begin
         nxt_done = 1'b0;
      end
      if (wr_st & pwdata[`ADCSC_ST_TRIG_OVR]) begin
         nxt_trig_ovr = 1'b0;
      end
      if (wr_st & pwdata[`ADCSC_ST_RES_OVR]) begin
         nxt_res_ovr = 1'b0;
      end
      if (wr_c5 | (rd_res & fast_clr)) begin
         nxt_done = 1'b0;
      end
      if (abort_req) begin
         nxt_trig_ovr = 1'b0;
      end
      if (wr_c5 | trig_start) begin
         nxt_res_ovr = 1'b0;
      end
      // Without fast clear a result read clears only after a flag read
      if (rd_ccf) begin
         nxt_armed = 1'b1;
      end
      if (rd_res) begin
         if (fast_clr | armed_ff) begin
            nxt_ccf[res_idx] = 1'b0;
         end
         nxt_armed = 1'b0;
      end
      if (wr_c5) begin
         nxt_ccf = 8'h00;
      end
      if (seq_end) begin
         nxt_done = 1'b1;
      end
      if (trig_overrun) begin
         nxt_trig_ovr = 1'b1;
      end
      if (store) begin
         if (ccf_ff[cnt_ff]) begin
            nxt_res_ovr = 1'b1;
         end
         nxt_ccf[cnt_ff] = 1'b1;
      end
   end

   // ****************************************************************
   // Read mux
   // ****************************************************************

   // Built at setup; the test register answers with noise on purpose
   always @* begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      if (is_res) begin
         rd_mux = {16'h0000, result_ff[res_idx]};
      end else begin
         case (paddr)
            `ADCSC_OFF_CTL_TWO: rd_mux = {24'h000000, ctl_two_ff};
            `ADCSC_OFF_CTL_THREE: rd_mux = {24'h000000, ctl_three_ff};
            `ADCSC_OFF_CTL_FOUR: rd_mux = {24'h000000, ctl_four_ff};
            `ADCSC_OFF_SEQ_CTL: rd_mux = {24'h000000, seq_ctl_ff};
            `ADCSC_OFF_SEQ_STAT: begin
               rd_mux = {24'h000000, done_ff, 1'b0, trig_ovr_ff,
                         res_ovr_ff, 1'b0, cnt_ff};
            end
            `ADCSC_OFF_DONE_FLAGS: rd_mux = {24'h000000, ccf_ff};
            `ADCSC_OFF_TEST_ZERO: begin
               rd_mux = {24'h000000, lfsr_ff ^ test_ff};
            end
            default: rd_err = 1'b1;
         endcase
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************

   // Bus answer is one wait-free access cycle after setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= psel & ~penable;
         if (psel & ~penable) begin
            pslverr_ff <= rd_err;
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
         end else begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   // Software control registers and free-running noise source
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_two_ff <= `ADCSC_RST_CTL_TWO;
         ctl_three_ff <= `ADCSC_RST_CTL_THREE;
         ctl_four_ff <= `ADCSC_RST_CTL_FOUR;
         seq_ctl_ff <= `ADCSC_RST_SEQ_CTL;
         test_ff <= 8'h00;
         lfsr_ff <= `ADCSC_RST_LFSR;
      end else begin
         lfsr_ff <= {lfsr_ff[6:0],
                     lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
         if (wr_c2) begin
            ctl_two_ff <= {5'h00, pwdata[2:0]};
         end
         if (wr_c3) begin
            ctl_three_ff <= {3'h0, pwdata[4:0]};
         end
         if (wr_c4) begin
            ctl_four_ff <= {7'h00, pwdata[0]};
         end
         if (wr_c5) begin
            seq_ctl_ff <= pwdata[7:0] & `ADCSC_SC_WMASK;
         end
         // Ignored outside special mode
         if (wr_tst & special_mode) begin
            test_ff <= pwdata[7:0];
         end
      end
   end

   // Sequencer, flag and result storage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_ff <= 1'b0;
         wait_ff <= 1'b0;
         start_ff <= 1'b0;
         abort_ff <= 1'b0;
         pos_ff <= 4'h0;
         chan_ff <= 3'h0;
         cnt_ff <= 3'h0;
         done_ff <= 1'b0;
         trig_ovr_ff <= 1'b0;
         res_ovr_ff <= 1'b0;
         armed_ff <= 1'b0;
         ccf_ff <= 8'h00;
         for (i = 0; i < 8; i = i + 1) begin
            result_ff[i] <= 16'h0000;
         end
      end else begin
         busy_ff <= nxt_busy;
         wait_ff <= nxt_wait;
         start_ff <= nxt_start;
         abort_ff <= nxt_abort;
         pos_ff <= nxt_pos;
         chan_ff <= nxt_chan;
         cnt_ff <= nxt_cnt;
         done_ff <= nxt_done;
         trig_ovr_ff <= nxt_trig_ovr;
         res_ovr_ff <= nxt_res_ovr;
         armed_ff <= nxt_armed;
         ccf_ff <= nxt_ccf;
         if (store) begin
            result_ff[cnt_ff] <= adcsc_format(conv_data,
               ctl_four_ff[`ADCSC_C4_LOW_RES],
               seq_ctl_ff[`ADCSC_SC_JUSTIFY],
               seq_ctl_ff[`ADCSC_SC_SIGNED]);
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign conv_start = start_ff;
   assign conv_abort = abort_ff;
   assign conv_channel = chan_ff;
   assign conv_low_res = ctl_four_ff[`ADCSC_C4_LOW_RES];
   assign seq_busy = busy_ff;

endmodule // adcsc_seq_ctrl

//--- hw/adcsc_defs.vh
// Register map, field positions, reset values and codes for the
// converter sequence controller.
// Assumes an 8-bit APB byte address; every register is one aligned word.
`ifndef ADCSC_DEFS_VH
`define ADCSC_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ADCSC_OFF_CTL_TWO 8'h00
`define ADCSC_OFF_CTL_THREE 8'h04
`define ADCSC_OFF_CTL_FOUR 8'h08
`define ADCSC_OFF_SEQ_CTL 8'h0c
`define ADCSC_OFF_SEQ_STAT 8'h10
`define ADCSC_OFF_DONE_FLAGS 8'h14
`define ADCSC_OFF_TEST_ZERO 8'h18
// Result registers 0..7 sit at 0x20..0x3c
`define ADCSC_RES_BASE_HI 3'h1

// ****************************************************************
// Field positions
// ****************************************************************
// converter_control_two
`define ADCSC_C2_FAST_CLR 0
`define ADCSC_C2_TRIG_EDGE_SEL 1
`define ADCSC_C2_TRIG_EN 2
// converter_control_three
`define ADCSC_C3_FIFO 4
// converter_control_four
`define ADCSC_C4_LOW_RES 0
// sequence_control
`define ADCSC_SC_JUSTIFY 7
`define ADCSC_SC_SIGNED 6
`define ADCSC_SC_CONT 5
`define ADCSC_SC_MULTI 4
`define ADCSC_SC_WMASK 8'hf7
// sequence_status
`define ADCSC_ST_DONE 7
`define ADCSC_ST_TRIG_OVR 5
`define ADCSC_ST_RES_OVR 4

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define ADCSC_RST_CTL_TWO 8'h00
`define ADCSC_RST_CTL_THREE 8'h04
`define ADCSC_RST_CTL_FOUR 8'h00
`define ADCSC_RST_SEQ_CTL 8'h00
`define ADCSC_RST_LFSR 8'h5a
`define ADCSC_MAX_LEN 4'h8

`endif

//--- tb/adcsc_seq_ctrl_assertions.sv
// Checker on the ports of the converter sequence controller.
// Assumes a bind to adcsc_seq_ctrl and presetn as the only reset.
`timescale 1ns/10ps
`include "adcsc_defs.vh"
module adcsc_chk (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic ext_trigger,
   input logic special_mode,
   input logic conv_done,
   input logic [9:0] conv_data,
   input logic conv_start,
   input logic conv_abort,
   input logic [2:0] conv_channel,
   input logic conv_low_res,
   input logic seq_busy
);
   logic wr, wr_sc, wr_ctl, multi_ff, have_ff, out_ff;
   logic [2:0] prev_ff;
   logic [3:0] len_ff, pos_ff;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****************
   // Write decode and tracking
   // ****************
   assign wr = psel && penable && pready && pwrite;
   assign wr_sc = wr && paddr == `ADCSC_OFF_SEQ_CTL;
   assign wr_ctl = wr && paddr < `ADCSC_OFF_SEQ_STAT; // Controls only
   // History is dropped at each start so a new sequence is not a step
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         multi_ff <= 1'b0;
         have_ff <= 1'b0;
         out_ff <= 1'b0;
         prev_ff <= 3'h0;
         len_ff <= 4'h4; // Control three resets to a length of four
         pos_ff <= 4'h0;
      end else begin
         if (wr_sc) multi_ff <= pwdata[`ADCSC_SC_MULTI];
         // Length 0 or above 8 means a full sequence of 8
         if (wr && paddr == `ADCSC_OFF_CTL_THREE) begin
            len_ff <= (pwdata[3:0] == 4'h0 ||
               pwdata[3:0] > `ADCSC_MAX_LEN) ? `ADCSC_MAX_LEN : pwdata[3:0];
         end
         // A continuous sequence returns to its start code: not a step
         if (wr_sc || !seq_busy) begin
            have_ff <= 1'b0;
            pos_ff <= 4'h0;
         end else if (conv_start) begin
            have_ff <= (pos_ff + 4'h1 != len_ff);
            pos_ff <= (pos_ff + 4'h1 == len_ff) ? 4'h0 : pos_ff + 4'h1;
         end
         if (conv_start) prev_ff <= conv_channel;
         if (conv_start) out_ff <= 1'b1;
         else if (conv_done || conv_abort) out_ff <= 1'b0;
      end
   end
   // ****************
   // Properties
   // ****************
   chk_restart_write: assert property (
      wr_sc |=> seq_busy ##1 conv_start) else $error("no restart");
   chk_abort_flight: assert property (
      wr_ctl && out_ff |-> ##[1:2] conv_abort) else $error("no abort");
   chk_abort_stops: assert property (
      wr_ctl && !wr_sc && seq_busy |-> ##[1:2] !seq_busy)
      else $error("sequence kept running");
   chk_chan_direct: assert property (
      wr_sc |=> conv_channel == $past(pwdata[2:0]))
      else $error("channel code not applied");
   chk_chan_hold: assert property (
      seq_busy && $past(seq_busy) && !$past(wr_sc) && !multi_ff
      |-> $stable(conv_channel)) else $error("single channel moved");
   chk_chan_step: assert property (
      conv_start && multi_ff && have_ff |-> conv_channel == prev_ff + 3'h1)
      else $error("channel step wrong");
   chk_idle_quiet: assert property (
      !seq_busy |-> !conv_start) else $error("start while idle");
   chk_res_follow: assert property (
      wr && paddr == `ADCSC_OFF_CTL_FOUR |=> conv_low_res == $past(pwdata[0]))
      else $error("resolution not applied");
   cover property (wr_sc ##1 seq_busy);
   cover property (conv_abort);
   cover property (conv_start && multi_ff && have_ff && conv_channel == 3'h0);
endmodule // adcsc_chk
bind adcsc_seq_ctrl adcsc_chk adcsc_chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ext_trigger(ext_trigger), .special_mode(special_mode),
   .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
   .conv_abort(conv_abort), .conv_channel(conv_channel),
   .conv_low_res(conv_low_res), .seq_busy(seq_busy));

//--- tb/adcsc_core_model.sv
// Behavioural converter core: one answer per start, prompt or slow.
// Assumes starts and aborts are one-cycle pulses on pclk.
`timescale 1ns/10ps
module adcsc_core_model (
   input logic pclk,
   input logic presetn,
   input logic conv_start,
   input logic conv_abort,
   input logic [2:0] conv_channel,
   input logic slow,
   input logic [6:0] code_hi,
   output logic conv_done,
   output logic [9:0] conv_data
);
   int cnt;
   logic [9:0] last;
   // Result carries the channel in its low bits so order can be seen
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         conv_done <= 1'b0;
         conv_data <= 10'h000;
         last <= 10'h000;
      end else begin
         conv_done <= 1'b0;
         conv_data <= ~last; // Stale data is never left on the lines
         if (conv_start) cnt <= slow ? 40 : 3;
         else if (conv_abort) cnt <= 0;
         else if (cnt == 1) begin
            conv_done <= 1'b1;
            conv_data <= {code_hi, conv_channel};
            last <= {code_hi, conv_channel};
            cnt <= 0;
         end else if (cnt != 0) cnt <= cnt - 1;
      end
   end
endmodule // adcsc_core_model

//--- tb/adc_sequence_control_test.sv
// Self-checking bench for the converter sequence controller.
// Assumes the core model answers each start; APB master is this bench.
`timescale 1ns/10ps
`include "adcsc_defs.vh"
module adc_sequence_control_test;
   localparam logic [7:0] c2 = `ADCSC_OFF_CTL_TWO;
   localparam logic [7:0] c3 = `ADCSC_OFF_CTL_THREE;
   localparam logic [7:0] c4 = `ADCSC_OFF_CTL_FOUR;
   localparam logic [7:0] sq = `ADCSC_OFF_SEQ_CTL;
   localparam logic [7:0] st = `ADCSC_OFF_SEQ_STAT;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_trigger;
   logic special_mode, conv_done, conv_start, conv_abort, conv_low_res;
   logic seq_busy, slow;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [9:0] conv_data;
   logic [2:0] conv_channel;
   logic [6:0] code_hi;
   logic e;
   int miscompares, num_checks, cycles;
   adcsc_seq_ctrl adcsc_seq_ctrl_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_trigger(ext_trigger), .special_mode(special_mode),
      .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
      .conv_abort(conv_abort), .conv_channel(conv_channel),
      .conv_low_res(conv_low_res), .seq_busy(seq_busy));
   adcsc_core_model adcsc_core_model_i (.pclk(pclk), .presetn(presetn),
      .conv_start(conv_start), .conv_abort(conv_abort),
      .conv_channel(conv_channel), .slow(slow), .code_hi(code_hi),
      .conv_done(conv_done), .conv_data(conv_data));
   // ****************
   // Shared tasks
   // ****************
   always #5 pclk = ~pclk;
   // Hang guard: far above the longest path through the scenarios
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] x, g);
      num_checks++;
      if (g !== x) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", s, x, g);
      end
   endtask
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      q = 32'h0;
      while (q[7] !== 1'b1 && n < 400) begin
         apb(1'b0, st, 32'h0);
         n++;
      end
      chk("sequence done", 32'h1, {31'h0, q[7]});
   endtask
   task automatic trig();
      ext_trigger <= 1'b1;
      repeat (6) @(posedge pclk);
      ext_trigger <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      apb(1'b0, c3, 32'h0);
      chk("control three reset", 32'h04, q);
      apb(1'b0, sq, 32'h0);
      chk("sequence control reset", 32'h00, q);
      apb(1'b0, st, 32'h0);
      chk("status reset", 32'h00, q);
      apb(1'b1, 8'h1c, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, e});
   endtask
   task automatic t_format();
      logic [15:0] x;
      logic [9:0] c;
      wr(c3, 32'h1);
      c = {code_hi, 3'h3};
      for (int i = 0; i < 8; i++) begin
         x = i[2] ? {8'h00, c[9:2]} : {6'h00, c};
         if (!i[1]) x = i[2] ? {x[7:0], 8'h00} : {c, 6'h00};
         if (!i[1] && i[0]) x[15] = ~x[15];
         wr(c4, {31'h0, i[2]});
         wr(sq, {24'h0, i[1], i[0], 6'h03});
         wait_done();
         apb(1'b0, 8'h20, 32'h0);
         chk("result format", {16'h0, x}, q);
      end
   endtask
   task automatic t_multi();
      wr(c3, 32'h0);
      wr(c4, 32'h0);
      wr(sq, 32'h96);
      wait_done();
      for (int n = 0; n < 8; n++) begin
         apb(1'b0, 8'h20 + 8'(4 * n), 32'h0);
         chk("multi channel", {29'h0, 3'(n + 6)}, {29'h0, q[2:0]});
      end
      apb(1'b0, st, 32'h0);
      chk("status after multi", 32'h80, q);
      wr(st, 32'h0);
      apb(1'b0, st, 32'h0);
      chk("status write zero", 32'h80, q);
      wr(st, 32'h80);
      apb(1'b0, st, 32'h0);
      chk("status write one", 32'h00, q);
   endtask
   task automatic t_cont();
      slow <= 1'b1;
      wr(c3, 32'h1);
      wr(sq, 32'h22);
      wait_done();
      wr(st, 32'h80);
      wait_done();
      chk("continuous busy", 32'h1, {31'h0, seq_busy});
      wr(sq, 32'h02);
      apb(1'b0, st, 32'h0);
      chk("done after restart", 32'h0, {31'h0, q[7]});
      wait_done();
      repeat (3) @(posedge pclk);
      chk("single sequence ends", 32'h0, {31'h0, seq_busy});
      wr(sq, 32'h22);
      repeat (10) @(posedge pclk);
      wr(c2, 32'h0);
      apb(1'b0, st, 32'h0);
      chk("counter after abort", 32'h0, {29'h0, q[2:0]});
   endtask
   task automatic t_fifo();
      slow <= 1'b0;
      wr(c2, 32'h04);
      wr(c3, 32'h13);
      wr(sq, 32'h01);
      wait_done();
      apb(1'b0, st, 32'h0);
      chk("fifo counter kept", 32'h83, q);
      wr(st, 32'hff);
      apb(1'b0, st, 32'h0);
      chk("counter read only", 32'h03, q);
      trig();
      wait_done();
      apb(1'b0, st, 32'h0);
      chk("trigger sequence", 32'h86, q);
      wr(st, 32'h80);
      trig();
      wait_done();
      apb(1'b0, st, 32'h0);
      chk("wrap and overrun", 32'h91, q);
      slow <= 1'b1;
      wr(st, 32'h80);
      trig();
      trig();
      apb(1'b0, st, 32'h0);
      chk("trigger overrun", 32'h2, {30'h0, q[5:4]});
      wr(c4, 32'h0);
      apb(1'b0, st, 32'h0);
      chk("overrun cleared", 32'h0, {31'h0, q[5]});
      chk("counter after fifo abort", 32'h0, {29'h0, q[2:0]});
      // Fast clear: a result read alone drops the done flag
      wr(c2, 32'h01);
      wr(sq, 32'h00);
      wait_done();
      apb(1'b0, 8'h20, 32'h0);
      apb(1'b0, st, 32'h0);
      chk("fast clear on read", 32'h0, {31'h0, q[7]});
      // Level mode starts on a held level and never flags overrun
      wr(c2, 32'h06);
      ext_trigger <= 1'b1;
      wait_done();
      ext_trigger <= 1'b0;
      chk("level mode overrun", 32'h0, {31'h0, q[5]});
   endtask
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, ext_trigger, special_mode, slow} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      code_hi = 7'h41;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_format();
      t_multi();
      t_cont();
      t_fifo();
      complete_run();
   end
endmodule // adc_sequence_control_test
